// File: dtec_defs.vh
`ifndef DTEC_DEFS_VH
`define DTEC_DEFS_VH

// ==========================================================
// special-function addresses
`define DTEC_ADDR_CTRL01 8'h88
`define DTEC_ADDR_MODE01 8'h89
`define DTEC_ADDR_TL0 8'h8a
`define DTEC_ADDR_TL1 8'h8b
`define DTEC_ADDR_TH0 8'h8c
`define DTEC_ADDR_TH1 8'h8d
`define DTEC_ADDR_CFG2 8'hc8
`define DTEC_ADDR_TL2 8'hcc
`define DTEC_ADDR_TH2 8'hcd
`define DTEC_ADDR_PLL 8'hd7

// ==========================================================
// reset values
`define DTEC_RST_CTRL01 8'h00
`define DTEC_RST_MODE01 8'h00
`define DTEC_RST_CFG2 8'h00
`define DTEC_RST_PLL 8'h03
`define DTEC_RST_BYTE 8'h00

// ==========================================================
// field positions
`define DTEC_MODE_GATE1 7
`define DTEC_MODE_CT1 6
`define DTEC_MODE_M_HI1 5
`define DTEC_MODE_M_LO1 4
`define DTEC_MODE_GATE0 3
`define DTEC_MODE_CT0 2
`define DTEC_MODE_M_HI0 1
`define DTEC_MODE_M_LO0 0
`define DTEC_CTRL_OVF1 7
`define DTEC_CTRL_RUN1 6
`define DTEC_CTRL_OVF0 5
`define DTEC_CTRL_RUN0 4
`define DTEC_CFG2_OVF 7
`define DTEC_CFG2_RUN 2
`define DTEC_CFG2_CT 1
`define DTEC_PLL_CD_HI 2
`define DTEC_PLL_CD_LO 0

// ==========================================================
// count modes
`define DTEC_MODE_PRESCALE 2'h0
`define DTEC_MODE_CASCADE 2'h1
`define DTEC_MODE_RELOAD 2'h2
`define DTEC_MODE_STOP 2'h3

// ==========================================================
// machine cycle timing, in core clock periods
`define DTEC_CORE_PER_MACHINE 4'hc
`define DTEC_PHASE_LAST 4'hb
`define DTEC_PHASE_S3P1 4'h4
`define DTEC_PHASE_S5P2 4'h9

`endif

// File: dtec_chan.v
`include "dtec_defs.vh"

module dtec_chan #(
  parameter W = 8
) (
  input wire clk,
  input wire reset_n,
  input wire sample_en,
  input wire inc_en,
  input wire pin_level,
  input wire run,
  input wire count_sel,
  input wire [1:0] mode,
  input wire wr_low,
  input wire wr_high,
  input wire [W-1:0] wdata,
  output reg [W-1:0] low_byte,
  output reg [W-1:0] high_byte,
  output reg overflow
);

  reg last_sample;
  reg edge_pend;
  wire count_now;
  wire [2*W:0] sum16;
  wire [13:0] sum13;
  wire [W:0] sum8;

  // ==========================================================
  // edge detection at the sample point
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_sample <= 1'b0;
      edge_pend <= 1'b0;
    end else begin
      if (sample_en) begin
        last_sample <= pin_level;
        if (last_sample && !pin_level) begin
          edge_pend <= 1'b1;
        end
      end else if (inc_en) begin
        edge_pend <= 1'b0;
      end
    end
  end

  // one count step per machine cycle at most
  assign count_now = inc_en && run && (mode != `DTEC_MODE_STOP) &&
    (count_sel ? edge_pend : 1'b1);
  assign sum16 = {1'b0, high_byte, low_byte} + 17'h00001;
  assign sum13 = {1'b0, high_byte, low_byte[4:0]} + 14'h0001;
  assign sum8 = {1'b0, low_byte} + 9'h001;

  // ==========================================================
  // counter bytes; a software write beats a count step
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_byte <= `DTEC_RST_BYTE;
      high_byte <= `DTEC_RST_BYTE;
      overflow <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (wr_low || wr_high) begin
        if (wr_low) begin
          low_byte <= wdata;
        end
        if (wr_high) begin
          high_byte <= wdata;
        end
      end else if (count_now) begin
        case (mode)
          `DTEC_MODE_PRESCALE: begin
            low_byte <= {low_byte[7:5], sum13[4:0]};
            high_byte <= sum13[12:5];
            overflow <= sum13[13];
          end
          `DTEC_MODE_CASCADE: begin
            low_byte <= sum16[W-1:0];
            high_byte <= sum16[2*W-1:W];
            overflow <= sum16[2*W];
          end
          `DTEC_MODE_RELOAD: begin
            low_byte <= sum8[W] ? high_byte : sum8[W-1:0];
            overflow <= sum8[W];
          end
          default: begin
            low_byte <= low_byte;
          end
        endcase
      end
    end
  end

endmodule

// File: dtec_timers.v
// Overview of operation
// - three 16-bit timer/counters, each with separate 8-bit high and low bytes
// - each one runs as a timer or as an external event counter
// - timer function adds one per machine cycle of 12 core clocks
// - counter function adds one per falling edge on its count input pin
// - pin sampled once per machine cycle at S5P2; high then low is an edge
// - the counted edge shows in the register at S3P1 of the next cycle
// - one edge needs two machine cycles, so at most core clock over 24
// - three divider bits in the pll control register set the core clock
// - timers 0 and 1 share mode and control registers; timer 2 has its own
// - shared mode register at 89h, resets to 00h, byte access only
// - gating bit set means run needs irq pin high and run bit set
// - select bit set counts the pin; clear counts machine cycles
// - mode 00 prescaled 8-bit, 01 16-bit, 10 auto-reload, 11 stopped
// - shared control register at 88h, resets to 00h, bit addressable
`include "dtec_defs.vh"

module dtec_timers #(
  parameter W = 8,
  parameter NPIN = 5
) (
  input wire clk,
  input wire reset_n,
  input wire [W-1:0] sfr_addr,
  input wire sfr_wr,
  input wire [W-1:0] sfr_wdata,
  input wire sfr_bit_wr,
  input wire [W-1:0] sfr_bit_addr,
  input wire sfr_bit_data,
  input wire count_input_pin_0,
  input wire count_input_pin_1,
  input wire count_input_pin_2,
  input wire ext_irq_pin_0,
  input wire ext_irq_pin_1,
  output reg [W-1:0] sfr_rdata,
  output reg core_tick
);

  // ==========================================================
  // decoding shared by the two bit-addressable registers
  function bit_hit;
    input [W-1:0] bit_addr;
    input [W-1:0] reg_addr;
    begin
      bit_hit = (bit_addr[7:3] == reg_addr[7:3]);
    end
  endfunction

  function [W-1:0] bit_apply;
    input [W-1:0] value;
    input [2:0] sel;
    input bit_val;
    reg [W-1:0] mask;
    begin
      mask = 8'h01 << sel;
      bit_apply = bit_val ? (value | mask) : (value & ~mask);
    end
  endfunction

  // ==========================================================
  // per-channel address decoding, shared by the write strobes
  function [W-1:0] low_addr;
    input integer idx;
    begin
      case (idx)
        0: low_addr = `DTEC_ADDR_TL0;
        1: low_addr = `DTEC_ADDR_TL1;
        default: low_addr = `DTEC_ADDR_TL2;
      endcase
    end
  endfunction

  function [W-1:0] high_addr;
    input integer idx;
    begin
      case (idx)
        0: high_addr = `DTEC_ADDR_TH0;
        1: high_addr = `DTEC_ADDR_TH1;
        default: high_addr = `DTEC_ADDR_TH2;
      endcase
    end
  endfunction

  // mode field of timer 0 or 1 inside the shared mode register
  function [1:0] mode_field;
    input [W-1:0] value;
    input idx;
    begin
      mode_field = idx ?
        {value[`DTEC_MODE_M_HI1], value[`DTEC_MODE_M_LO1]} :
        {value[`DTEC_MODE_M_HI0], value[`DTEC_MODE_M_LO0]};
    end
  endfunction

  // with the gate bit set the synced irq pin must also be high
  function run_gate;
    input run_bit;
    input gate;
    input pin;
    begin
      run_gate = run_bit && (!gate || pin);
    end
  endfunction

  reg [W-1:0] timer01_mode_reg;
  reg [W-1:0] timer01_control_reg;
  reg [W-1:0] timer2_config_reg;
  reg [W-1:0] pll_control_reg;
  reg [W-1:0] next_ctrl;
  reg [W-1:0] next_cfg2;
  reg [W-1:0] next_rdata;
  reg [NPIN-1:0] sync1;
  reg [NPIN-1:0] sync2;
  reg [NPIN-1:0] sync3;
  reg [NPIN-1:0] pin_level;
  reg [6:0] div_cnt;
  reg [3:0] phase;
  wire [NPIN-1:0] pin_raw;
  wire [2:0] core_divider_select;
  wire [6:0] div_limit;
  wire div_wrap;
  wire sample_en;
  wire inc_en;
  wire [2:0] run;
  wire [2:0] count_sel;
  wire [5:0] modes;
  wire [2:0] wr_low;
  wire [2:0] wr_high;
  wire [3*W-1:0] low_bytes;
  wire [3*W-1:0] high_bytes;
  wire [2:0] overflow;
  wire gate0;
  wire gate1;
  wire run_bit_0;
  wire run_bit_1;

  // ==========================================================
  // pin synchronisers
  // a level is accepted only once the second and third stages agree
  assign pin_raw = {ext_irq_pin_1, ext_irq_pin_0, count_input_pin_2,
    count_input_pin_1, count_input_pin_0};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          pin_level[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            pin_level[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // core clock divider and machine cycle phases
  // the core clock is modelled as a one-cycle tick of clk divided by 2^n
  assign core_divider_select =
    pll_control_reg[`DTEC_PLL_CD_HI:`DTEC_PLL_CD_LO];
  assign div_limit = (7'h01 << core_divider_select) - 7'h01;
  assign div_wrap = (div_cnt >= div_limit);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= 7'h00;
      core_tick <= 1'b0;
    end else begin
      core_tick <= div_wrap;
      if (div_wrap) begin
        div_cnt <= 7'h00;
      end else begin
        div_cnt <= div_cnt + 7'h01;
      end
    end
  end

  // twelve core periods per machine cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 4'h0;
    end else if (core_tick) begin
      if (phase == `DTEC_PHASE_LAST) begin
        phase <= 4'h0;
      end else begin
        phase <= phase + 4'h1;
      end
    end
  end

  assign sample_en = core_tick && (phase == `DTEC_PHASE_S5P2);
  assign inc_en = core_tick && (phase == `DTEC_PHASE_S3P1);

  // ==========================================================
  // per-timer configuration
  assign gate0 = timer01_mode_reg[`DTEC_MODE_GATE0];
  assign gate1 = timer01_mode_reg[`DTEC_MODE_GATE1];
  assign run_bit_0 = timer01_control_reg[`DTEC_CTRL_RUN0];
  assign run_bit_1 = timer01_control_reg[`DTEC_CTRL_RUN1];
  // the synced irq pins sit at pin_level[3] and pin_level[4]
  assign run[0] = run_gate(run_bit_0, gate0, pin_level[3]);
  assign run[1] = run_gate(run_bit_1, gate1, pin_level[4]);
  assign run[2] = timer2_config_reg[`DTEC_CFG2_RUN];
  assign count_sel[0] = timer01_mode_reg[`DTEC_MODE_CT0];
  assign count_sel[1] = timer01_mode_reg[`DTEC_MODE_CT1];
  assign count_sel[2] = timer2_config_reg[`DTEC_CFG2_CT];
  assign modes[1:0] = mode_field(timer01_mode_reg, 1'b0);
  assign modes[3:2] = mode_field(timer01_mode_reg, 1'b1);
  // timer 2 only runs the plain 16-bit count here
  assign modes[5:4] = `DTEC_MODE_CASCADE;

  // byte writes only; counter bytes are not bit addressable
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_wr
      assign wr_low[gi] = sfr_wr && (sfr_addr == low_addr(gi));
      assign wr_high[gi] = sfr_wr && (sfr_addr == high_addr(gi));
    end
  endgenerate

  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_chan
      dtec_chan #(
        .W(W)
      ) u_chan (
        .clk(clk),
        .reset_n(reset_n),
        .sample_en(sample_en),
        .inc_en(inc_en),
        .pin_level(pin_level[gi]),
        .run(run[gi]),
        .count_sel(count_sel[gi]),
        .mode(modes[2*gi+1:2*gi]),
        .wr_low(wr_low[gi]),
        .wr_high(wr_high[gi]),
        .wdata(sfr_wdata),
        .low_byte(low_bytes[W*gi+W-1:W*gi]),
        .high_byte(high_bytes[W*gi+W-1:W*gi]),
        .overflow(overflow[gi])
      );
    end
  endgenerate

  // ==========================================================
  // bit-addressable registers; an overflow in the write cycle still sets
  always @* begin
    next_ctrl = timer01_control_reg;
    if (sfr_wr && sfr_addr == `DTEC_ADDR_CTRL01) begin
      next_ctrl = sfr_wdata;
    end else if (sfr_bit_wr && bit_hit(sfr_bit_addr, `DTEC_ADDR_CTRL01)) begin
      next_ctrl = bit_apply(timer01_control_reg, sfr_bit_addr[2:0],
        sfr_bit_data);
    end
    next_ctrl[`DTEC_CTRL_OVF0] = next_ctrl[`DTEC_CTRL_OVF0] | overflow[0];
    next_ctrl[`DTEC_CTRL_OVF1] = next_ctrl[`DTEC_CTRL_OVF1] | overflow[1];
  end

  always @* begin
    next_cfg2 = timer2_config_reg;
    if (sfr_wr && sfr_addr == `DTEC_ADDR_CFG2) begin
      next_cfg2 = sfr_wdata;
    end else if (sfr_bit_wr && bit_hit(sfr_bit_addr, `DTEC_ADDR_CFG2)) begin
      next_cfg2 = bit_apply(timer2_config_reg, sfr_bit_addr[2:0],
        sfr_bit_data);
    end
    next_cfg2[`DTEC_CFG2_OVF] = next_cfg2[`DTEC_CFG2_OVF] | overflow[2];
  end

  // ==========================================================
  // byte-wide registers; the mode register ignores bit writes
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer01_mode_reg <= `DTEC_RST_MODE01;
      timer01_control_reg <= `DTEC_RST_CTRL01;
      timer2_config_reg <= `DTEC_RST_CFG2;
      pll_control_reg <= `DTEC_RST_PLL;
    end else begin
      timer01_control_reg <= next_ctrl;
      timer2_config_reg <= next_cfg2;
      if (sfr_wr && sfr_addr == `DTEC_ADDR_MODE01) begin
        timer01_mode_reg <= sfr_wdata;
      end
      if (sfr_wr && sfr_addr == `DTEC_ADDR_PLL) begin
        pll_control_reg <= sfr_wdata;
      end
    end
  end

  // ==========================================================
  // read path, registered; unmapped addresses read zero
  always @* begin
    case (sfr_addr)
      `DTEC_ADDR_CTRL01: next_rdata = timer01_control_reg;
      `DTEC_ADDR_MODE01: next_rdata = timer01_mode_reg;
      `DTEC_ADDR_TL0: next_rdata = low_bytes[W-1:0];
      `DTEC_ADDR_TL1: next_rdata = low_bytes[2*W-1:W];
      `DTEC_ADDR_TH0: next_rdata = high_bytes[W-1:0];
      `DTEC_ADDR_TH1: next_rdata = high_bytes[2*W-1:W];
      `DTEC_ADDR_CFG2: next_rdata = timer2_config_reg;
      `DTEC_ADDR_TL2: next_rdata = low_bytes[3*W-1:2*W];
      `DTEC_ADDR_TH2: next_rdata = high_bytes[3*W-1:2*W];
      `DTEC_ADDR_PLL: next_rdata = pll_control_reg;
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= next_rdata;
    end
  end

endmodule

// File: dtec_event_src.sv
// ==========================================================
// falling-edge source for one count input pin
module dtec_event_src (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic go,
  input wire logic [7:0] n,
  input wire logic [7:0] hold,
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left, tmr;
  // idles high like a pulled-up port pin, so no edge leaks between bursts
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin <= 1'b1;
      busy <= 1'b0;
      left <= 8'h00;
      tmr <= 8'h00;
    end else if (!busy) begin
      if (go && n != 8'h00) begin
        pin <= 1'b0;
        busy <= 1'b1;
        left <= n;
        tmr <= hold - 8'h01;
      end
    end else if (tmr != 8'h00) begin
      tmr <= tmr - 8'h01;
    end else if (!pin) begin
      pin <= 1'b1;
      left <= left - 8'h01;
      tmr <= hold - 8'h01;
    end else if (left != 8'h00) begin
      pin <= 1'b0;
      tmr <= hold - 8'h01;
    end else begin
      busy <= 1'b0;
    end
  end
endmodule

// File: dtec_timers_properties.sv
// ==========================================================
// port checker for the timer block
module dtec_timers_props (
  input wire clk,
  input wire reset_n,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire sfr_bit_wr,
  input wire [7:0] sfr_bit_addr,
  input wire sfr_bit_data,
  input wire count_input_pin_0,
  input wire count_input_pin_1,
  input wire count_input_pin_2,
  input wire ext_irq_pin_0,
  input wire ext_irq_pin_1,
  input wire [7:0] sfr_rdata,
  input wire core_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] steady, gap, irq_lo, pin_hi, cd_age;
  logic [3:0] m0;
  logic [2:0] cd;
  logic r0, mode_wr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // config is shadowed from the bus, so checks only trust long quiet spans
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      m0 <= 4'h0;
      r0 <= 1'b0;
      cd <= 3'h3;
      cd_age <= 8'h00;
      mode_wr <= 1'b0;
      steady <= 8'h00;
    end else begin
      if (sfr_wr && sfr_addr == 8'h89) m0 <= sfr_wdata[3:0];
      if (sfr_wr && sfr_addr == 8'h89) mode_wr <= 1'b1;
      if (sfr_wr && sfr_addr == 8'h88) r0 <= sfr_wdata[4];
      else if (sfr_bit_wr && sfr_bit_addr == 8'h8c) r0 <= sfr_bit_data;
      if (sfr_wr && sfr_addr == 8'hd7) cd <= sfr_wdata[2:0];
      cd_age <= (sfr_wr && sfr_addr == 8'hd7) ? 8'h00 : cd_age + {7'h0, ~&cd_age};
      steady <= (sfr_wr || sfr_bit_wr || sfr_addr != 8'h8a) ? 8'h00 :
        steady + {7'h0, ~&steady};
    end
  end
  always @(posedge clk) begin
    gap <= $changed(sfr_rdata) ? 8'h00 : gap + {7'h0, ~&gap};
    irq_lo <= ext_irq_pin_0 ? 8'h00 : irq_lo + {7'h0, ~&irq_lo};
    pin_hi <= count_input_pin_0 ? pin_hi + {7'h0, ~&pin_hi} : 8'h00;
  end
  mode_write_a: assert property ((sfr_wr && sfr_addr == 8'h89) ##1
    (sfr_addr == 8'h89 && !sfr_wr) |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("mode register readback wrong");
  mode_reset_a: assert property (!mode_wr && sfr_addr == 8'h89 && !sfr_wr
    |=> sfr_rdata == 8'h00) else $error("mode register not cleared");
  mode_bit_a: assert property ((sfr_bit_wr && sfr_bit_addr[7:3] == 5'h11 &&
    !sfr_wr && sfr_addr == 8'h89) ##1 (sfr_addr == 8'h89 && !sfr_wr &&
    !sfr_bit_wr) |=> $stable(sfr_rdata)) else $error("mode bit written");
  ctrl_bit_a: assert property ((sfr_bit_wr && sfr_bit_addr == 8'h8b &&
    !sfr_wr) ##1 (!sfr_wr && !sfr_bit_wr) ##1 (sfr_addr == 8'h88 && !sfr_wr &&
    !sfr_bit_wr) |=> sfr_rdata[3] == $past(sfr_bit_data, 3))
    else $error("control bit write lost");
  tick_fast_a: assert property (cd == 3'h0 && cd_age > 8'd16 |-> core_tick)
    else $error("core tick missing at full rate");
  tick_div_a: assert property (cd == 3'h3 && cd_age > 8'd16 && core_tick
    |=> !core_tick [*7] ##1 core_tick) else $error("core tick not every 8");
  timer_rate_a: assert property (steady > 8'd30 && m0[2:0] == 3'h1 && r0 &&
    (!m0[3] || ext_irq_pin_0) && cd == 3'h0 && $changed(sfr_rdata) |->
    gap == 8'd11 && sfr_rdata - $past(sfr_rdata) == 8'h01)
    else $error("timer step not one per 12 clocks");
  count_freeze_a: assert property (steady > 8'd30 && cd == 3'h0 &&
    (m0[1:0] == 2'h3 || !r0 || (m0[3] && irq_lo > 8'd20) ||
    (m0[2] && pin_hi > 8'd40)) |-> $stable(sfr_rdata))
    else $error("stopped timer moved");
  cover property (steady > 8'd30 && m0 == 4'h1 && $changed(sfr_rdata));
  cover property (steady > 8'd30 && m0[2] && $changed(sfr_rdata));
  cover property (steady > 8'd30 && m0[3] && irq_lo > 8'd20);
endmodule

bind dtec_timers dtec_timers_props u_props (
  .clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_addr(sfr_bit_addr),
  .sfr_bit_data(sfr_bit_data), .count_input_pin_0(count_input_pin_0),
  .count_input_pin_1(count_input_pin_1), .count_input_pin_2(count_input_pin_2),
  .ext_irq_pin_0(ext_irq_pin_0), .ext_irq_pin_1(ext_irq_pin_1),
  .sfr_rdata(sfr_rdata), .core_tick(core_tick)
);

// File: dtec_timers_bench.sv
// ==========================================================
// self-checking bench for the timer block
module dtec_timers_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset_n = 1'b0, sfr_wr = 1'b0, sfr_bit_wr = 1'b0;
  logic sfr_bit_data = 1'b0, irq0 = 1'b1, irq1 = 1'b1, go = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00;
  logic [7:0] src_n = 8'h00, src_hold = 8'h0c, v, tl, th, ctl;
  logic [1:0] sel = 2'h3;
  logic [16:0] e;
  wire src_pin, src_busy, core_tick;
  wire [7:0] sfr_rdata;
  int err_count = 0, tests_run = 0, seed, t, m, k, b;
  logic [7:0] regs [10] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
    8'hc8, 8'hcc, 8'hcd, 8'hd7};
  logic [7:0] tla [3] = '{8'h8a, 8'h8b, 8'hcc};
  logic [7:0] tha [3] = '{8'h8c, 8'h8d, 8'hcd};
  logic [7:0] runa [3] = '{8'h8c, 8'h8e, 8'hca};
  logic [7:0] flga [3] = '{8'h88, 8'h88, 8'hc8};
  int fb [3] = '{5, 7, 7};
  always #2 clk = ~clk;
  dtec_timers dut (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_addr(sfr_bit_addr), .sfr_bit_data(sfr_bit_data),
    .count_input_pin_0(sel == 2'h0 ? src_pin : 1'b1),
    .count_input_pin_1(sel == 2'h1 ? src_pin : 1'b1),
    .count_input_pin_2(sel == 2'h2 ? src_pin : 1'b1),
    .ext_irq_pin_0(irq0), .ext_irq_pin_1(irq1), .sfr_rdata(sfr_rdata),
    .core_tick(core_tick));
  dtec_event_src src (.clk(clk), .reset_n(reset_n), .go(go), .n(src_n),
    .hold(src_hold), .pin(src_pin), .busy(src_busy));
  task check(input string what, input logic [16:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task bwr(input logic [7:0] a, input logic d);
    @(posedge clk);
    sfr_bit_addr <= a;
    sfr_bit_data <= d;
    sfr_bit_wr <= 1'b1;
    @(posedge clk);
    sfr_bit_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    repeat (2) @(posedge clk);
    #1 d = sfr_rdata;
  endtask
  // returns {overflow, high, low} after n count steps
  function automatic logic [16:0] tmr_next(input logic [1:0] md,
      input logic [7:0] l0, h0, input int n);
    logic [7:0] l, h;
    logic o;
    l = l0;
    h = h0;
    o = 1'b0;
    repeat (n) case (md)
      2'h0: begin
        l[4:0] = l[4:0] + 5'h01;
        if (l[4:0] == 5'h00) {o, h} = {o | (h == 8'hff), h + 8'h01};
      end
      2'h1: begin
        l = l + 8'h01;
        if (l == 8'h00) {o, h} = {o | (h == 8'hff), h + 8'h01};
      end
      2'h2: {o, l} = l == 8'hff ? {1'b1, h} : {o, l + 8'h01};
      default: ;
    endcase
    return {o, h, l};
  endfunction
  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // the whole run is a few thousand cycles; this is far beyond it
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    end_of_test;
  end
  initial begin
    seed = $urandom(31);
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    foreach (regs[i]) begin
      rd(regs[i], v);
      check("reset value", v, {9'h0, regs[i] == 8'hd7 ? 8'h03 : 8'h00});
    end
    // full-rate core clock keeps a machine cycle at 12 bench clocks
    wr(8'hd7, 8'h00);
    rd(8'hd7, v);
    check("divider", v, 17'h0);
    repeat (4) begin
      v = 8'($urandom);
      wr(8'h89, v);
      rd(8'h89, tl);
      check("mode reg", tl, v);
    end
    ctl = 8'h00;
    for (b = 0; b < 4; b++) begin
      v[0] = 1'($urandom);
      bwr(8'h88 + 8'(b), v[0]);
      ctl[b] = v[0];
      rd(8'h88, th);
      check("ctrl bit", th, ctl);
      rd(8'h89, th);
      check("mode kept", th, tl);
    end
    wr(8'h88, 8'h00);
    // pass 4 is mode 01 with gating on and the gate pin held low
    for (t = 0; t < 3; t++) for (m = 0; m < 5; m++) begin
      if (t == 2 && m != 1) continue;
      k = 3 + $urandom % 18;
      tl = 8'hf0 | 8'($urandom);
      th = 8'hfe | 8'($urandom);
      irq0 <= m != 4;
      irq1 <= m != 4;
      v = 8'({m == 4 || $urandom % 2 == 1, 1'b0, m == 4 ? 2'h1 : 2'(m)});
      wr(t == 2 ? 8'hc8 : 8'h89, t == 2 ? 8'h00 : v << (4 * t));
      wr(tha[t], th);
      wr(tla[t], tl);
      rd(tla[t], v);
      check("preload", v, tl);
      bwr(runa[t], 1'b1);
      repeat (12 * k - 2) @(posedge clk);
      bwr(runa[t], 1'b0);
      e = m >= 3 ? {1'b0, th, tl} : tmr_next(2'(m), tl, th, k);
      rd(tla[t], v);
      check("low byte", v, e[7:0]);
      rd(tha[t], v);
      check("high byte", v, e[15:8]);
      rd(flga[t], v);
      check("overflow", v[fb[t]], e[16]);
      wr(flga[t], 8'h00);
    end
    for (t = 0; t < 3; t++) begin
      wr(t == 2 ? 8'hc8 : 8'h89, t == 2 ? 8'h02 : 8'h05 << (4 * t));
      tl = 8'($urandom);
      th = 8'($urandom);
      wr(tha[t], th);
      wr(tla[t], tl);
      rd(tla[t], v);
      bwr(runa[t], 1'b1);
      k = 1 + $urandom % 10;
      sel <= 2'(t);
      src_n <= 8'(k);
      src_hold <= t == 0 ? 8'd12 : 8'd12 + 8'($urandom % 8);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
      b = 0;
      while (src_busy && b < 2000) begin
        @(posedge clk);
        b++;
      end
      repeat (48) @(posedge clk);
      bwr(runa[t], 1'b0);
      e = tmr_next(2'h1, tl, th, k);
      rd(tla[t], v);
      check("event count", v, e[7:0]);
      rd(tha[t], v);
      check("event high", v, e[15:8]);
      wr(flga[t], 8'h00);
    end
    end_of_test;
  end
endmodule
